/* design/frt_timer.sv */
// Free running 16-bit timer with one-pulse mode and APB registers
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - High byte read first latches low byte
// - Latched low byte frozen until low read
// - Lone low read returns live count
// - Wrap from maximum sets overflow flag
// - Overflow request gated by enable and mask
// - Overflow clears: status read, clearing low access
// - Alternate low access never clears overflow
// - Halt stops counter; wait has no effect
// - Clock select both ones picks external pin
// - Edge select bit picks external active edge
// - External pin sampled on falling edge
// - One-pulse bit joins capture one, compare one
// - Pulse start: load counter, pin, flag, capture
// - Capture flag requests when capture enabled
// - Capture flag clears: status, low access
// - Compare one match drives after level
// - Compare value is ticks minus four
// - One-pulse: compare one flag never sets
// - Modulation bit overrides one-pulse mode
// - Capture one restarts counter, two still captures
// - Compare two flags only, no waveform
module frt_timer (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Processor state
  input  wire logic                global_irq_mask,
  input  wire logic                halt_mode,
  // Pins
  input  wire frt_pkg::frt_pins_type pins,
  output logic                     compare_one_pin,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic prev,
                                    input logic cur,
                                    input logic rising);
    edge_hit = rising ? (cur & ~prev) : (~cur & prev);
  endfunction : edge_hit

  function automatic logic [31:0] word(input logic [7:0] b);
    word = {24'h000000, b};
  endfunction : word

  function automatic logic [7:0] status_of(input logic [4:0] f);
    status_of                    = 8'h00;
    status_of[frt_pkg::S_CAP1]   = f[frt_pkg::F_CAP1];
    status_of[frt_pkg::S_CMP1]   = f[frt_pkg::F_CMP1];
    status_of[frt_pkg::S_OVF]    = f[frt_pkg::F_OVF];
    status_of[frt_pkg::S_CAP2]   = f[frt_pkg::F_CAP2];
    status_of[frt_pkg::S_CMP2]   = f[frt_pkg::F_CMP2];
  endfunction : status_of

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= frt_pkg::A_CMP2_LO) &&
             (a[1:0] == frt_pkg::A_ALIGN);
  endfunction : mapped

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  frt_pkg::frt_state_type s_r;
  frt_pkg::frt_state_type s_nxt;
  logic                   tick;
  logic                   rd;
  logic                   wr;
  logic                   acc;
  logic                   one_pulse_enable;
  logic                   ev1;
  logic                   ev2;
  logic [15:0]            inc;
  logic [4:0]             set;
  logic [4:0]             clr;
  logic                   match1;
  logic                   match2;

  // Reads act at setup so data and side effects see one snapshot
  assign rd  = psel & ~penable & ~pwrite;
  assign wr  = psel & penable & pwrite;
  assign acc = rd | wr;
  assign one_pulse_enable = s_r.ctrl_two[frt_pkg::B_OPM] &
               ~s_r.ctrl_two[frt_pkg::B_PWM];
  assign ev1 = edge_hit(s_r.cap1_prev, pins.capture_one_pin,
                        s_r.ctrl_one[frt_pkg::B_CAP1_EDGE]);
  assign ev2 = edge_hit(s_r.cap2_prev, pins.capture_two_pin,
                        s_r.ctrl_one[frt_pkg::B_CAP2_EDGE]);
  assign inc = s_r.count + frt_pkg::CNT_STEP;
  // Match on the step so the level changes once, not every cycle
  assign match1 = tick & (inc == s_r.cmp1);
  assign match2 = tick & (inc == s_r.cmp2);

  // Halt gates the tick; wait mode is not an input at all
  frt_tick u_tick (
    .clock      (clock),
    .reset      (reset),
    .sel        (s_r.ctrl_two[frt_pkg::B_CLK_HI:frt_pkg::B_CLK_LO]),
    .ext_rising (s_r.ctrl_two[frt_pkg::B_EXT_EDGE]),
    .run        (~halt_mode),
    .ext_pin    (pins.external_clock_pin),
    .tick       (tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt           = s_r;
    set             = 5'h00;
    clr             = 5'h00;
    s_nxt.cap1_prev = pins.capture_one_pin;
    s_nxt.cap2_prev = pins.capture_two_pin;

    // Counting and compare
    if (tick) begin
      s_nxt.count = inc;
      if (s_r.count == frt_pkg::CNT_MAX) begin
        set[frt_pkg::F_OVF] = 1'b1;
      end
    end
    if (match1) begin
      if (one_pulse_enable) begin
        s_nxt.pin = s_r.ctrl_one[frt_pkg::B_AFTER];
      end else begin
        set[frt_pkg::F_CMP1] = 1'b1;
        s_nxt.pin = s_r.ctrl_one[frt_pkg::B_AFTER];
      end
    end
    if (match2) begin
      set[frt_pkg::F_CMP2] = 1'b1;
    end

    // Capture; pulse start overrides a same-cycle step
    if (ev1) begin
      set[frt_pkg::F_CAP1] = 1'b1;
      if (one_pulse_enable) begin
        s_nxt.count = frt_pkg::OPM_LOAD;
        s_nxt.pin   = s_r.ctrl_one[frt_pkg::B_DURING];
        s_nxt.cap1  = frt_pkg::OPM_CAPT;
      end else begin
        s_nxt.cap1 = s_r.count;
      end
    end
    if (ev2) begin
      set[frt_pkg::F_CAP2] = 1'b1;
      s_nxt.cap2           = s_r.count;
    end

    // Register reads
    if (rd) begin
      case (paddr)
        frt_pkg::A_CTRL_ONE: begin
          s_nxt.prdata = word(s_r.ctrl_one);
        end
        frt_pkg::A_CTRL_TWO: begin
          s_nxt.prdata = word(s_r.ctrl_two);
        end
        frt_pkg::A_STATUS: begin
          s_nxt.prdata = word(status_of(s_r.flags));
          s_nxt.armed  = s_r.armed | s_r.flags;
        end
        frt_pkg::A_CNT_HI, frt_pkg::A_ALT_HI: begin
          s_nxt.prdata = word(s_r.count[15:8]);
          if (!s_r.latched) begin
            s_nxt.latched   = 1'b1;
            s_nxt.low_latch = s_r.count[7:0];
          end
        end
        frt_pkg::A_CNT_LO, frt_pkg::A_ALT_LO: begin
          s_nxt.prdata  = word(s_r.latched ? s_r.low_latch
                                           : s_r.count[7:0]);
          s_nxt.latched = 1'b0;
        end
        frt_pkg::A_CAP1_HI: begin
          s_nxt.prdata = word(s_r.cap1[15:8]);
        end
        frt_pkg::A_CAP1_LO: begin
          s_nxt.prdata = word(s_r.cap1[7:0]);
        end
        frt_pkg::A_CAP2_HI: begin
          s_nxt.prdata = word(s_r.cap2[15:8]);
        end
        frt_pkg::A_CAP2_LO: begin
          s_nxt.prdata = word(s_r.cap2[7:0]);
        end
        frt_pkg::A_CMP1_HI: begin
          s_nxt.prdata = word(s_r.cmp1[15:8]);
        end
        frt_pkg::A_CMP1_LO: begin
          s_nxt.prdata = word(s_r.cmp1[7:0]);
        end
        frt_pkg::A_CMP2_HI: begin
          s_nxt.prdata = word(s_r.cmp2[15:8]);
        end
        frt_pkg::A_CMP2_LO: begin
          s_nxt.prdata = word(s_r.cmp2[7:0]);
        end
        default: begin
          s_nxt.prdata = 32'h00000000;
        end
      endcase
    end

    // Register writes
    if (wr) begin
      case (paddr)
        frt_pkg::A_CTRL_ONE: begin
          s_nxt.ctrl_one = pwdata[7:0];
        end
        frt_pkg::A_CTRL_TWO: begin
          s_nxt.ctrl_two = pwdata[7:0];
        end
        frt_pkg::A_CMP1_HI: begin
          s_nxt.cmp1[15:8] = pwdata[7:0];
        end
        frt_pkg::A_CMP1_LO: begin
          s_nxt.cmp1[7:0] = pwdata[7:0];
        end
        frt_pkg::A_CMP2_HI: begin
          s_nxt.cmp2[15:8] = pwdata[7:0];
        end
        frt_pkg::A_CMP2_LO: begin
          s_nxt.cmp2[7:0] = pwdata[7:0];
        end
        default: begin
          s_nxt.prdata = s_r.prdata;
        end
      endcase
    end

    // Flag clearing; alternate view is left out on purpose
    if (acc) begin
      case (paddr)
        frt_pkg::A_CNT_LO:  clr[frt_pkg::F_OVF]  = 1'b1;
        frt_pkg::A_CAP1_LO: clr[frt_pkg::F_CAP1] = 1'b1;
        frt_pkg::A_CAP2_LO: clr[frt_pkg::F_CAP2] = 1'b1;
        frt_pkg::A_CMP1_LO: clr[frt_pkg::F_CMP1] = 1'b1;
        frt_pkg::A_CMP2_LO: clr[frt_pkg::F_CMP2] = 1'b1;
        default:            clr                  = 5'h00;
      endcase
    end
    clr = clr & s_r.armed;
    // A new event in the clearing cycle survives
    s_nxt.flags = set | (s_r.flags & ~clr);
    s_nxt.armed = s_nxt.armed & ~clr & s_nxt.flags;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r <= frt_pkg::ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata  = s_r.prdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign compare_one_pin = s_r.ctrl_two[frt_pkg::B_PIN_EN] & s_r.pin;
  // Flags stay pending while masked
  assign irq = ~global_irq_mask & (
      (s_r.flags[frt_pkg::F_OVF] &
       s_r.ctrl_one[frt_pkg::B_OVF_IE]) |
      ((s_r.flags[frt_pkg::F_CAP1] | s_r.flags[frt_pkg::F_CAP2]) &
       s_r.ctrl_one[frt_pkg::B_CAP_IE]) |
      ((s_r.flags[frt_pkg::F_CMP1] | s_r.flags[frt_pkg::F_CMP2]) &
       s_r.ctrl_one[frt_pkg::B_CMP_IE]));

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  ovf_wrap_a: assert property (
    tick && s_r.count == frt_pkg::CNT_MAX |=>
      s_r.flags[frt_pkg::F_OVF] && s_r.count == 16'h0000 ||
      $past(ev1 && one_pulse_enable))
    else $error("overflow flag not set on wrap");

  irq_mask_a: assert property (
    global_irq_mask |-> !irq)
    else $error("interrupt raised while masked");

  irq_pend_a: assert property (
    s_r.flags[frt_pkg::F_OVF] && s_r.ctrl_one[frt_pkg::B_OVF_IE] &&
    !global_irq_mask |-> irq)
    else $error("pending overflow request not issued");

  alt_keep_a: assert property (
    s_r.flags[frt_pkg::F_OVF] && acc &&
    (paddr == frt_pkg::A_ALT_LO || paddr == frt_pkg::A_ALT_HI)
    |=> s_r.flags[frt_pkg::F_OVF])
    else $error("alternate access cleared overflow");

  ovf_clear_a: assert property (
    rd && paddr == frt_pkg::A_STATUS && s_r.flags[frt_pkg::F_OVF]
    ##[1:8] (acc && paddr == frt_pkg::A_CNT_LO && !set[frt_pkg::F_OVF])
    |=> !s_r.flags[frt_pkg::F_OVF])
    else $error("overflow not cleared by sequence");

  halt_hold_a: assert property (
    halt_mode && !(ev1 && one_pulse_enable) |=> $stable(s_r.count))
    else $error("counter moved in halt");

  latch_hold_a: assert property (
    s_r.latched && !(rd && (paddr == frt_pkg::A_CNT_LO ||
                            paddr == frt_pkg::A_ALT_LO))
    |=> s_r.latched && $stable(s_r.low_latch))
    else $error("latched low byte changed");

  pulse_start_a: assert property (
    one_pulse_enable && ev1 |=> s_r.count == frt_pkg::OPM_LOAD &&
      s_r.cap1 == frt_pkg::OPM_CAPT && s_r.flags[frt_pkg::F_CAP1] &&
      s_r.pin == $past(s_r.ctrl_one[frt_pkg::B_DURING]))
    else $error("pulse start incomplete");

  pulse_end_a: assert property (
    one_pulse_enable && match1 && !ev1 |=>
      s_r.pin == $past(s_r.ctrl_one[frt_pkg::B_AFTER]))
    else $error("pulse end level wrong");

  opm_cmp1_a: assert property (
    one_pulse_enable && !s_r.flags[frt_pkg::F_CMP1] && !wr |=>
      !s_r.flags[frt_pkg::F_CMP1])
    else $error("compare one flag set in one-pulse mode");

  pulse_c: cover property (one_pulse_enable && ev1 ##[1:300] one_pulse_enable && match1);
  wrap_c: cover property (tick && s_r.count == frt_pkg::CNT_MAX);
  seq_c: cover property (
    rd && paddr == frt_pkg::A_CNT_HI ##[1:20]
    rd && paddr == frt_pkg::A_CNT_LO);

endmodule : frt_timer

`default_nettype wire

/* design/frt_pkg.sv */
// Constants and carrier types for the free running timer
package frt_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL_ONE = 8'h00;
  localparam logic [7:0] A_CTRL_TWO = 8'h04;
  localparam logic [7:0] A_STATUS   = 8'h08;
  localparam logic [7:0] A_CNT_HI   = 8'h0c;
  localparam logic [7:0] A_CNT_LO   = 8'h10;
  localparam logic [7:0] A_ALT_HI   = 8'h14;
  localparam logic [7:0] A_ALT_LO   = 8'h18;
  localparam logic [7:0] A_CAP1_HI  = 8'h1c;
  localparam logic [7:0] A_CAP1_LO  = 8'h20;
  localparam logic [7:0] A_CAP2_HI  = 8'h24;
  localparam logic [7:0] A_CAP2_LO  = 8'h28;
  localparam logic [7:0] A_CMP1_HI  = 8'h2c;
  localparam logic [7:0] A_CMP1_LO  = 8'h30;
  localparam logic [7:0] A_CMP2_HI  = 8'h34;
  localparam logic [7:0] A_CMP2_LO  = 8'h38;
  localparam logic [1:0] A_ALIGN    = 2'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_CAP_IE    = 7;
  localparam int B_CMP_IE    = 6;
  localparam int B_OVF_IE    = 5;
  localparam int B_CAP1_EDGE = 4;
  localparam int B_CAP2_EDGE = 3;
  localparam int B_DURING    = 2;
  localparam int B_AFTER     = 1;
  localparam int B_PIN_EN    = 7;
  localparam int B_PWM       = 5;
  localparam int B_OPM       = 4;
  localparam int B_CLK_HI    = 3;
  localparam int B_CLK_LO    = 2;
  localparam int B_EXT_EDGE  = 1;
  localparam int S_CAP1      = 7;
  localparam int S_CMP1      = 6;
  localparam int S_OVF       = 5;
  localparam int S_CAP2      = 4;
  localparam int S_CMP2      = 3;
  localparam int F_OVF       = 0;
  localparam int F_CAP1      = 1;
  localparam int F_CAP2      = 2;
  localparam int F_CMP1      = 3;
  localparam int F_CMP2      = 4;

  // ----------------------------------------------------------------
  // Clock select, prescaler and counter values
  // ----------------------------------------------------------------
  localparam logic [1:0]  CS_DIV4   = 2'h0;
  localparam logic [1:0]  CS_DIV2   = 2'h1;
  localparam logic [1:0]  CS_DIV8   = 2'h2;
  localparam logic [1:0]  CS_EXT    = 2'h3;
  localparam logic [2:0]  PRE_DIV2  = 3'h1;
  localparam logic [2:0]  PRE_DIV4  = 3'h3;
  localparam logic [2:0]  PRE_DIV8  = 3'h7;
  localparam logic [2:0]  PRE_STEP  = 3'h1;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_STEP  = 16'h0001;
  localparam logic [15:0] OPM_LOAD  = 16'hfffc;
  localparam logic [15:0] OPM_CAPT  = 16'hfffd;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic capture_one_pin;
    logic capture_two_pin;
    logic external_clock_pin;
  } frt_pins_type;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  low_latch;
    logic        latched;
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [4:0]  flags;
    logic [4:0]  armed;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic        pin;
    logic        cap1_prev;
    logic        cap2_prev;
    logic [31:0] prdata;
  } frt_state_type;

  typedef struct packed {
    logic [2:0] pre;
    logic       sync_b;
    logic       sync_c;
  } frt_tick_type;

  localparam frt_state_type ST_RESET = '{count: CNT_RESET, default: '0};

endpackage : frt_pkg

/* design/frt_tick.sv */
// Timer clock tick source: prescaler or synchronised external edge
`timescale 1ns/1ps
`default_nettype none

module frt_tick (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Selection
  input  wire logic [1:0] sel,
  input  wire logic       ext_rising,
  input  wire logic       run,
  // Pin
  input  wire logic       ext_pin,
  // Result
  output logic            tick
);

  // ----------------------------------------------------------------
  // External pin synchroniser
  // ----------------------------------------------------------------
  // First stage on the falling edge, as the counter expects
  logic                  sync_a_r;
  frt_pkg::frt_tick_type t_r;
  frt_pkg::frt_tick_type t_nxt;
  logic                  ext_hit;
  logic                  pre_hit;

  always_ff @(negedge clock or posedge reset) begin
    if (reset) begin
      sync_a_r <= 1'b0;
    end else begin
      sync_a_r <= ext_pin;
    end
  end

  function automatic logic pre_done(input logic [1:0] s,
                                    input logic [2:0] p);
    case (s)
      frt_pkg::CS_DIV2: pre_done = (p[0] == frt_pkg::PRE_DIV2[0]);
      frt_pkg::CS_DIV8: pre_done = (p == frt_pkg::PRE_DIV8);
      default:          pre_done = (p[1:0] == frt_pkg::PRE_DIV4[1:0]);
    endcase
  endfunction : pre_done

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  always_comb begin
    t_nxt        = t_r;
    t_nxt.sync_b = sync_a_r;
    t_nxt.sync_c = t_r.sync_b;
    if (run) begin
      t_nxt.pre = t_r.pre + frt_pkg::PRE_STEP; // Halt freezes prescaler
    end
  end

  assign ext_hit = ext_rising ? (t_r.sync_b & ~t_r.sync_c)
                              : (~t_r.sync_b & t_r.sync_c);
  assign pre_hit = pre_done(sel, t_r.pre);
  assign tick    = run & ((sel == frt_pkg::CS_EXT) ? ext_hit
                                                   : pre_hit);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

endmodule : frt_tick

`default_nettype wire

/* dv/frt_pins_model.sv */
// Far side pin model: capture pins and external clock source
`timescale 1ns/1ps
`default_nettype none

module frt_pins_model (
  // Clock
  input  wire logic                  clock,
  // Pins driven towards the timer
  output var frt_pkg::frt_pins_type  pins
);

  initial pins = '0;

  // Each phase spans four clocks so active edges never crowd the sync
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clock);
      pins.external_clock_pin <= 1'h1;
      repeat (4) @(posedge clock);
      pins.external_clock_pin <= 1'h0;
    end
    repeat (4) @(posedge clock);
  endtask : ext_pulses

  // Both capture pins move together, just after a clock edge
  task automatic cap_pins(input logic one, input logic two);
    @(posedge clock);
    pins.capture_one_pin <= one;
    pins.capture_two_pin <= two;
  endtask : cap_pins

endmodule : frt_pins_model
`default_nettype wire

/* dv/frt_timer_tb_top.sv */
// Self-checking testbench for the free running timer
`timescale 1ns/1ps
`default_nettype none

module frt_timer_tb_top;

  logic                  clock;
  logic                  reset;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  global_irq_mask;
  logic                  halt_mode;
  logic                  compare_one_pin;
  logic                  irq;
  frt_pkg::frt_pins_type pins;
  int                    n_mismatch;
  int                    n_tests;
  logic [31:0]           rd_data;
  logic                  rd_err;
  logic [31:0]           ref_val;
  logic [15:0]           cnt;

  frt_timer dut (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .global_irq_mask(global_irq_mask), .halt_mode(halt_mode),
    .pins(pins), .compare_one_pin(compare_one_pin), .irq(irq)
  );

  frt_pins_model pm (
    .clock(clock),
    .pins(pins)
  );

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'h1;
    // No wait limit here: the watchdog ends a bus that never answers
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, {24'h0, exp}, rd_data);
  endtask : rd

  // High byte first, low byte at the next word
  task automatic rd16(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
    cnt[15:8] = rd_data[7:0];
    apb(1'h0, a + 8'h04, 32'h0);
    cnt[7:0] = rd_data[7:0];
  endtask : rd16

  // Let the counter run for a number of clocks, then halt it again
  task automatic run_for(input int n);
    halt_mode <= 1'h0;
    repeat (n) @(posedge clock);
    halt_mode <= 1'h1;
  endtask : run_for

  task automatic close_out();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    close_out();
  end

  initial begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    global_irq_mask = 1'h1;
    halt_mode = 1'h1;
    n_mismatch = 0;
    n_tests = 0;
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    // Halted from reset, so the count must still be the reset count
    rd(frt_pkg::A_CTRL_ONE, 8'h00, "ctrl_one");
    rd(frt_pkg::A_CTRL_TWO, 8'h00, "ctrl_two");
    rd(frt_pkg::A_STATUS, 8'h00, "status");
    rd(frt_pkg::A_CNT_HI, 8'hff, "cnt_hi");
    rd(frt_pkg::A_CNT_LO, 8'hfc, "cnt_lo");
    apb(1'h0, 8'h3c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rd_err});
    chk("unmapped_data", 32'h0, rd_data);
    // Latch, then run past the wrap and freeze again
    apb(1'h0, frt_pkg::A_CNT_HI, 32'h0);
    apb(1'h1, frt_pkg::A_CTRL_ONE, 32'h20);
    // Compares parked far away so the wrap below sets no compare flag
    apb(1'h1, frt_pkg::A_CMP1_HI, 32'h80);
    apb(1'h1, frt_pkg::A_CMP2_HI, 32'h80);
    run_for(40);
    rd(frt_pkg::A_CNT_HI, 8'h00, "cnt_hi_wrap");
    rd(frt_pkg::A_CNT_LO, 8'hfc, "latched_lo");
    apb(1'h0, frt_pkg::A_CNT_LO, 32'h0);
    ref_val = rd_data;
    rd16(frt_pkg::A_CNT_HI);
    chk("live_lo", ref_val, {24'h0, cnt[7:0]});
    chk("live_moved", 32'h0, {31'h0, ref_val == 32'hfc});
    rd(frt_pkg::A_STATUS, 8'h20, "ovf_set");
    chk("irq_masked", 32'h0, {31'h0, irq});
    global_irq_mask <= 1'h0;
    repeat (2) @(posedge clock);
    chk("irq_open", 32'h1, {31'h0, irq});
    apb(1'h0, frt_pkg::A_ALT_LO, 32'h0);
    rd(frt_pkg::A_STATUS, 8'h20, "ovf_alt");
    apb(1'h1, frt_pkg::A_CNT_LO, 32'h0);
    rd(frt_pkg::A_STATUS, 8'h00, "ovf_clear");
    chk("irq_clear", 32'h0, {31'h0, irq});
    // Prescaler by eight, then by two, over 32 running clocks
    apb(1'h1, frt_pkg::A_CTRL_TWO, 32'h08);
    rd16(frt_pkg::A_ALT_HI);
    ref_val = {16'h0, cnt};
    run_for(32);
    rd16(frt_pkg::A_ALT_HI);
    chk("div8", ref_val + 32'h4, {16'h0, cnt});
    apb(1'h1, frt_pkg::A_CTRL_TWO, 32'h04);
    rd16(frt_pkg::A_ALT_HI);
    ref_val = {16'h0, cnt};
    run_for(32);
    rd16(frt_pkg::A_ALT_HI);
    chk("div2", ref_val + 32'h10, {16'h0, cnt});
    // External clock, rising then falling edges
    apb(1'h1, frt_pkg::A_CTRL_TWO, 32'h0e);
    halt_mode <= 1'h0;
    rd16(frt_pkg::A_ALT_HI);
    ref_val = {16'h0, cnt};
    pm.ext_pulses(3);
    rd16(frt_pkg::A_ALT_HI);
    chk("ext_rise", ref_val + 32'h3, {16'h0, cnt});
    apb(1'h1, frt_pkg::A_CTRL_TWO, 32'h0c);
    pm.ext_pulses(2);
    rd16(frt_pkg::A_ALT_HI);
    chk("ext_fall", ref_val + 32'h5, {16'h0, cnt});
    // One pulse, timed by external ticks
    apb(1'h1, frt_pkg::A_CTRL_ONE, 32'h9c);
    apb(1'h1, frt_pkg::A_CMP1_HI, 32'h0);
    apb(1'h1, frt_pkg::A_CMP1_LO, 32'h02);
    apb(1'h1, frt_pkg::A_CMP2_HI, 32'h0);
    apb(1'h1, frt_pkg::A_CMP2_LO, 32'h01);
    apb(1'h1, frt_pkg::A_CTRL_TWO, 32'h9e);
    pm.cap_pins(1'h1, 1'h0);
    repeat (6) @(posedge clock);
    chk("pin_during", 32'h1, {31'h0, compare_one_pin});
    chk("irq_cap", 32'h1, {31'h0, irq});
    rd16(frt_pkg::A_ALT_HI);
    chk("opm_load", 32'hfffc, {16'h0, cnt});
    rd(frt_pkg::A_STATUS, 8'h80, "cap1_set");
    rd(frt_pkg::A_CAP1_HI, 8'hff, "cap1_hi");
    rd(frt_pkg::A_CAP1_LO, 8'hfd, "cap1_lo");
    rd(frt_pkg::A_STATUS, 8'h00, "cap1_clear");
    pm.ext_pulses(5);
    chk("pin_hold", 32'h1, {31'h0, compare_one_pin});
    pm.ext_pulses(1);
    chk("pin_after", 32'h0, {31'h0, compare_one_pin});
    rd16(frt_pkg::A_ALT_HI);
    chk("opm_count", 32'h0002, {16'h0, cnt});
    pm.cap_pins(1'h1, 1'h1);
    rd(frt_pkg::A_STATUS, 8'h38, "opm_flags");
    rd(frt_pkg::A_CAP2_HI, 8'h00, "cap2_hi");
    rd(frt_pkg::A_CAP2_LO, 8'h02, "cap2_lo");
    // Modulation bit set: capture one edge no longer restarts
    apb(1'h1, frt_pkg::A_CTRL_TWO, 32'hbe);
    pm.cap_pins(1'h0, 1'h1);
    pm.cap_pins(1'h1, 1'h1);
    rd16(frt_pkg::A_ALT_HI);
    chk("pwm_no_load", 32'h0002, {16'h0, cnt});
    rd(frt_pkg::A_CAP1_LO, 8'h02, "pwm_cap1");
    close_out();
  end

endmodule : frt_timer_tb_top
`default_nettype wire
